// *** logic/cfd_pkg.sv ***
/*
  Package for the clamp and field detect block: register indices, field
  layout, reset values, timing constants and the pixel carrier.
  Assumes a 250 MHz system clock on the register bus side.
*/
package cfd_pkg;
  // ----------------------------------------------------------------
  // register indices (16-bit data, word index on ADDR)
  // ----------------------------------------------------------------
  localparam logic [3:0] CFD_HCLAMP_IDX = 4'h0;
  localparam logic [3:0] CFD_VBEGIN_IDX = 4'h1;
  localparam logic [3:0] CFD_VEND_IDX   = 4'h2;
  localparam logic [3:0] CFD_CTRL_IDX   = 4'h3;
  localparam logic [3:0] CFD_FIELD_IDX  = 4'h4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFD_HEND_LSB   = 8;
  localparam int CFD_INV_BIT    = 6;
  localparam int CFD_DRES_BIT   = 7;
  localparam int CFD_PINEN_BIT  = 8;
  localparam int CFD_FLAG_BIT   = 6;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CFD_HCLAMP_RST = 16'h0000;
  localparam logic [9:0]  CFD_VBEGIN_RST = 10'h000;
  localparam logic [9:0]  CFD_VEND_RST   = 10'h00A;
  localparam logic [8:0]  CFD_CTRL_RST   = 9'h000;
  localparam logic [5:0]  CFD_SPT2_RST   = 6'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CFD_CLK_NS    = 4;
  localparam int CFD_HUNIT_NS  = 480;
  localparam int CFD_VSTEP_NS  = 1920;
  localparam logic [8:0] CFD_HUNIT_CYC = 9'(CFD_HUNIT_NS / CFD_CLK_NS);
  localparam logic [8:0] CFD_VSTEP_CYC = 9'(CFD_VSTEP_NS / CFD_CLK_NS);
  localparam logic [8:0] CFD_HCNT_MAX  = 9'h1FF;
  localparam logic [6:0] CFD_VSCNT_MAX = 7'h7F;
  localparam logic [9:0] CFD_LINE_MAX  = 10'h3FF;
  // ----------------------------------------------------------------
  // pixel carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rgb;
    logic       blank;
    logic       cor;
  } cfd_pix_s;
  localparam cfd_pix_s CFD_PIX_RST = '{rgb: 3'h0, blank: 1'b0, cor: 1'b0};
endpackage : cfd_pkg

// *** logic/cfd_top.sv ***
/*
  Clamp window generation and interlaced field detection.
  Assumes HSYNC_PIN/VSYNC_PIN arrive asynchronously with normal polarity,
  PIX_IN comes from the layer mixer on CLK, and a plain register port.
*/
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module cfd_top (
  input  wire logic            CLK,
  input  wire logic            ARST_N,
  input  wire logic            CE,
  input  wire logic            HSYNC_PIN,
  input  wire logic            VSYNC_PIN,
  input  wire logic [3:0]      ADDR,
  input  wire logic [15:0]     WDATA,
  input  wire logic            WR,
  input  wire logic            RD,
  output logic      [15:0]     RDATA,
  input  cfd_pkg::cfd_pix_s    PIX_IN,
  output cfd_pkg::cfd_pix_s    PIX_OUT,
  output logic                 CLAMP,
  output logic                 FIELD_SEL,
  output logic                 FIELD_PIN,
  output logic                 FIELD_PIN_OE
);
  import cfd_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] hcl_q, hcl_d;
  logic [9:0]  vb_q, vb_d;
  logic [9:0]  ve_q, ve_d;
  logic [8:0]  ctl_q, ctl_d;
  logic [5:0]  spt2_q, spt2_d;
  logic [15:0] rd_q, rd_d;
  logic        det_q;

  always_comb begin
    hcl_d  = hcl_q;
    vb_d   = vb_q;
    ve_d   = ve_q;
    ctl_d  = ctl_q;
    spt2_d = spt2_q;
    rd_d   = rd_q;
    if (WR) begin
      unique case (ADDR)
        CFD_HCLAMP_IDX: hcl_d  = WDATA;
        CFD_VBEGIN_IDX: vb_d   = WDATA[9:0];
        CFD_VEND_IDX:   ve_d   = WDATA[9:0];
        CFD_CTRL_IDX:   ctl_d  = WDATA[8:0];
        CFD_FIELD_IDX:  spt2_d = WDATA[5:0];
        default:        ;
      endcase
    end
    if (RD) begin
      unique case (ADDR)
        CFD_HCLAMP_IDX: rd_d = hcl_q;
        CFD_VBEGIN_IDX: rd_d = {6'h00, vb_q};
        CFD_VEND_IDX:   rd_d = {6'h00, ve_q};
        CFD_CTRL_IDX:   rd_d = {7'h00, ctl_q};
        CFD_FIELD_IDX:  rd_d = {9'h000, det_q, spt2_q};
        default:        rd_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hcl_q  <= CFD_HCLAMP_RST;
      vb_q   <= CFD_VBEGIN_RST;
      ve_q   <= CFD_VEND_RST;
      ctl_q  <= CFD_CTRL_RST;
      spt2_q <= CFD_SPT2_RST;
      rd_q   <= 16'h0000;
    end else if (CE) begin
      hcl_q  <= hcl_d;
      vb_q   <= vb_d;
      ve_q   <= ve_d;
      ctl_q  <= ctl_d;
      spt2_q <= spt2_d;
      rd_q   <= rd_d;
    end
  end

  assign RDATA = rd_q;

  logic [7:0] hb;
  logic [7:0] he;
  logic [5:0] spt1;
  logic       flip;
  logic       dres;
  assign hb   = hcl_q[7:0];
  assign he   = hcl_q[CFD_HEND_LSB +: 8];
  assign spt1 = ctl_q[5:0];
  assign flip = ctl_q[CFD_INV_BIT];
  assign dres = ctl_q[CFD_DRES_BIT];

  // ----------------------------------------------------------------
  // sync inputs, line timing and vsync sampling
  // ----------------------------------------------------------------
  logic [2:0] hs_q, hs_d;
  logic [2:0] vs_q, vs_d;
  logic [8:0] hpre_q, hpre_d;
  logic [8:0] hcnt_q, hcnt_d;
  logic [8:0] vpre_q, vpre_d;
  logic [6:0] vcnt_q, vcnt_d;
  logic [9:0] line_q, line_d;
  logic       tk1_q, tk1_d, tk2_q, tk2_d;
  logic       s1_q, s1_d, s2_q, s2_d, s1p_q, s1p_d;
  logic       det_d;
  logic       hs_rise, vs_rise;

  // stage 0 is read only by stage 1; edges use stages 1 and 2
  assign hs_rise = hs_q[1] & ~hs_q[2];
  assign vs_rise = vs_q[1] & ~vs_q[2];

  always_comb begin
    hs_d   = {hs_q[1:0], HSYNC_PIN};
    vs_d   = {vs_q[1:0], VSYNC_PIN};
    hpre_d = hpre_q;
    hcnt_d = hcnt_q;
    vpre_d = vpre_q;
    vcnt_d = vcnt_q;
    line_d = line_q;
    tk1_d  = tk1_q;
    tk2_d  = tk2_q;
    s1_d   = s1_q;
    s2_d   = s2_q;
    s1p_d  = s1p_q;
    det_d  = det_q;
    if (hpre_q == CFD_HUNIT_CYC - 9'h001) begin
      hpre_d = 9'h000;
      if (hcnt_q != CFD_HCNT_MAX) hcnt_d = hcnt_q + 9'h001;
    end else begin
      hpre_d = hpre_q + 9'h001;
    end
    if (vpre_q == CFD_VSTEP_CYC - 9'h001) begin
      vpre_d = 9'h000;
      if (vcnt_q != CFD_VSCNT_MAX) vcnt_d = vcnt_q + 7'h01;
    end else begin
      vpre_d = vpre_q + 9'h001;
    end
    if (!tk1_q && vcnt_q >= {1'b0, spt1}) begin
      tk1_d = 1'b1;
      s1_d  = vs_q[1];
    end
    if (!tk2_q && vcnt_q >= {1'b0, spt2_q}) begin
      tk2_d = 1'b1;
      s2_d  = vs_q[1];
    end
    if (hs_rise) begin
      hpre_d = 9'h000;
      hcnt_d = 9'h000;
      vpre_d = 9'h000;
      vcnt_d = 7'h00;
      tk1_d  = 1'b0;
      tk2_d  = 1'b0;
      s1_d   = 1'b0;
      s2_d   = 1'b0;
      s1p_d  = s1_q;
      if (line_q != CFD_LINE_MAX) line_d = line_q + 10'h001;
      // first line with vsync seen decides the field, once per field
      if (s1_q && !s1p_q) det_d = ~s2_q;
    end
    if (vs_rise) line_d = 10'h000;
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hs_q   <= 3'h0;
      vs_q   <= 3'h0;
      hpre_q <= 9'h000;
      hcnt_q <= CFD_HCNT_MAX;
      vpre_q <= 9'h000;
      vcnt_q <= CFD_VSCNT_MAX;
      line_q <= CFD_LINE_MAX;
      tk1_q  <= 1'b1;
      tk2_q  <= 1'b1;
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s1p_q  <= 1'b0;
      det_q  <= 1'b0;
    end else if (CE) begin
      hs_q   <= hs_d;
      vs_q   <= vs_d;
      hpre_q <= hpre_d;
      hcnt_q <= hcnt_d;
      vpre_q <= vpre_d;
      vcnt_q <= vcnt_d;
      line_q <= line_d;
      tk1_q  <= tk1_d;
      tk2_q  <= tk2_d;
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s1p_q  <= s1p_d;
      det_q  <= det_d;
    end
  end

  // ----------------------------------------------------------------
  // clamp window, pixel override and field outputs
  // ----------------------------------------------------------------
  logic     hclamp, vclamp, clamp_c, field_c;
  logic     clamp_q, fsel_q, fpin_q, fpoe_q;
  logic     clamp_d, fsel_d, fpin_d, fpoe_d;
  cfd_pix_s pix_q, pix_d;

  always_comb begin
    if (hb <= he) begin
      hclamp = hcnt_q >= {1'b0, hb} && hcnt_q < {1'b0, he};
    end else begin
      hclamp = hcnt_q >= {1'b0, hb} || hcnt_q < {1'b0, he};
    end
    vclamp  = line_q >= vb_q && line_q < ve_q;
    clamp_c = hclamp | vclamp;
    field_c = det_q ^ flip;
    clamp_d = clamp_c;
    // field 0 = A = odd lines half, shown in raster alpha
    fsel_d  = dres & field_c;
    fpin_d  = field_c;
    fpoe_d  = ctl_q[CFD_PINEN_BIT];
    if (clamp_c) begin
      pix_d = '{rgb: 3'h0, blank: 1'b1, cor: 1'b0};
    end else begin
      pix_d = PIX_IN;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clamp_q <= 1'b0;
      fsel_q  <= 1'b0;
      fpin_q  <= 1'b0;
      fpoe_q  <= 1'b0;
      pix_q   <= CFD_PIX_RST;
    end else if (CE) begin
      clamp_q <= clamp_d;
      fsel_q  <= fsel_d;
      fpin_q  <= fpin_d;
      fpoe_q  <= fpoe_d;
      pix_q   <= pix_d;
    end
  end

  assign CLAMP        = clamp_q;
  assign FIELD_SEL    = fsel_q;
  assign FIELD_PIN    = fpin_q;
  assign FIELD_PIN_OE = fpoe_q;
  assign PIX_OUT      = pix_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence clamp_now_s;
    CE && clamp_c;
  endsequence

  sequence black_out_s;
    PIX_OUT.rgb == 3'h0 && PIX_OUT.blank && !PIX_OUT.cor && CLAMP;
  endsequence

  clamp_black_a: assert property (
    @(posedge CLK) disable iff (!ARST_N) clamp_now_s |=> black_out_s)
    else $error("clamp window did not force black output");

  clamp_pass_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && !clamp_c) |=> (PIX_OUT == $past(PIX_IN) && !CLAMP))
    else $error("pixel not passed outside clamp");

  hclamp_norm_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && hb <= he && (hcnt_q < {1'b0, hb} || hcnt_q >= {1'b0, he}) && !vclamp) |=> !CLAMP)
    else $error("horizontal clamp outside its window");

  hclamp_wrap_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && hb > he && hcnt_q < {1'b0, he}) |=> CLAMP)
    else $error("wrapped clamp misses hsync period");

  vclamp_win_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && line_q >= vb_q && line_q < ve_q) |=> CLAMP)
    else $error("vertical clamp lines not clamped");

  hunit_step_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && !hs_rise && hpre_q == CFD_HUNIT_CYC - 9'h001 && hcnt_q < 9'h0FF)
    |=> hcnt_q == $past(hcnt_q) + 9'h001)
    else $error("480 ns unit step wrong");

  sample_clear_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && hs_rise) |=> (!tk1_q && !tk2_q && vcnt_q == 7'h00))
    else $error("vsync samples not rearmed per line");

  field_odd_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && hs_rise && s1_q && !s1p_q) |=> det_q == !$past(s2_q))
    else $error("field decision wrong");

  field_hold_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && !(hs_rise && s1_q && !s1p_q)) |=> $stable(det_q))
    else $error("field changed outside vsync");

  field_sel_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    CE |=> FIELD_SEL == ($past(dres) & ($past(det_q) ^ $past(flip))))
    else $error("field select not inverted or gated");

  status_read_a: assert property (
    @(posedge CLK) disable iff (!ARST_N)
    (CE && RD && ADDR == CFD_FIELD_IDX) |=> RDATA[CFD_FLAG_BIT] == $past(det_q))
    else $error("status flag does not show field");

endmodule : cfd_top

// *** tb/cfd_sync_src.sv ***
/*
  Video sync source model: a free-running hsync and one vsync pulse per field.
  Assumes the bench picks the vsync length; from a fixed start, that length sets the field.
*/
`timescale 1ns/1ps
module cfd_sync_src #(
  parameter int LINE_CYC  = 1600,
  parameter int HS_CYC    = 60,
  parameter int FIELD_LNS = 5
) (
  input  wire logic        clk,
  input  wire logic [11:0] vs_start,
  input  wire logic [11:0] vs_len,
  output logic             hsync,
  output logic             vsync
);
  int pix_cnt  = 0;
  int line_cnt = 0;
  // --------------------------------------------------------------
  // raster counters
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (pix_cnt == LINE_CYC - 1) begin
      pix_cnt  <= 0;
      line_cnt <= (line_cnt == FIELD_LNS - 1) ? 0 : line_cnt + 1;
    end else begin
      pix_cnt <= pix_cnt + 1;
    end
  end
  assign hsync = (pix_cnt < HS_CYC);
  // a short pulse is seen at the first sample point only
  assign vsync = (line_cnt == 0) && (pix_cnt >= int'(vs_start))
                 && (pix_cnt < int'(vs_start) + int'(vs_len));
endmodule : cfd_sync_src

// *** tb/cfd_top_test.sv ***
/*
  Self-checking bench for the clamp and field detect block.
  Assumes the sync source model and a 250 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module cfd_top_test;
  import cfd_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        ce;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  cfd_pix_s    pix_out;
  logic        clamp;
  logic        field_sel;
  logic        field_pin;
  logic        field_pin_oe;
  logic        hsync;
  logic        vsync;
  logic [11:0] vs_len;
  logic [15:0] d;
  int          mismatches   = 0;
  int          total_checks = 0;
  logic [15:0] rst_val [6]  = '{16'h0000, 16'h0000, 16'h000A, 16'h0000, 16'h0000, 16'h0000};

  cfd_sync_src i_src (.clk(clk), .vs_start(12'h12C), .vs_len(vs_len), .hsync(hsync),
    .vsync(vsync));
  cfd_top i_dut (.CLK(clk), .ARST_N(arst_n), .CE(ce), .HSYNC_PIN(hsync), .VSYNC_PIN(vsync),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PIX_IN(5'h1F),
    .PIX_OUT(pix_out), .CLAMP(clamp), .FIELD_SEL(field_sel), .FIELD_PIN(field_pin),
    .FIELD_PIN_OE(field_pin_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // --------------------------------------------------------------
  // bus and check tasks
  // --------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  task automatic at_pos(input int n);
    @(posedge hsync);
    repeat (n) @(posedge clk);
    #1;
  endtask : at_pos
  task automatic chk_h(input int n, input logic exp);
    at_pos(n);
    `CHK(clamp, exp)
    `CHK(pix_out, exp ? 5'h02 : 5'h1F)
  endtask : chk_h
  task automatic field_case(input logic [11:0] len, input logic inv, input logic dres,
                            input logic det);
    vs_len <= len;
    wr_reg(CFD_CTRL_IDX, {7'h00, 1'b1, dres, inv, 6'h01});
    wr_reg(CFD_FIELD_IDX, 16'h0002);
    @(posedge vsync);
    repeat (3) @(posedge hsync);
    rd_reg(CFD_FIELD_IDX, d);
    `CHK(d, {9'h000, det, 6'h02})
    `CHK(field_pin, det ^ inv)
    `CHK(field_sel, dres & (det ^ inv))
    `CHK(field_pin_oe, 1'b1)
  endtask : field_case
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    ce     = 1'b1;
    addr   = 4'h0;
    wdata  = 16'h0000;
    wr     = 1'b0;
    rd     = 1'b0;
    vs_len = 12'd1000;
    repeat (4) @(posedge clk);
    `CHK({rdata, clamp, field_sel, field_pin, field_pin_oe, pix_out}, 25'h0000000)
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd_reg(4'(i), d);
      `CHK(d, rst_val[i])
    end
    wr_reg(CFD_VBEGIN_IDX, 16'hFFFF);
    rd_reg(CFD_VBEGIN_IDX, d);
    `CHK(d, 16'h03FF)
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(CFD_HCLAMP_IDX, 16'h0402);
    ce <= 1'b1;
    rd_reg(CFD_HCLAMP_IDX, d);
    `CHK(d, 16'h0000)
    wr_reg(CFD_HCLAMP_IDX, 16'h0402);
    wr_reg(CFD_VEND_IDX, 16'h0000);
    rd_reg(CFD_HCLAMP_IDX, d);
    `CHK(d, 16'h0402)
    $display("test registers done");
    chk_h(100, 1'b0);
    chk_h(360, 1'b1);
    chk_h(600, 1'b0);
    wr_reg(CFD_HCLAMP_IDX, 16'h0204);
    chk_h(100, 1'b1);
    chk_h(360, 1'b0);
    chk_h(600, 1'b1);
    $display("test horizontal clamp done");
    wr_reg(CFD_HCLAMP_IDX, 16'h0000);
    wr_reg(CFD_VBEGIN_IDX, 16'h0002);
    wr_reg(CFD_VEND_IDX, 16'h0004);
    @(posedge vsync);
    for (int i = 1; i < 5; i++) begin
      at_pos(800);
      `CHK(clamp, (i == 2 || i == 3))
    end
    $display("test vertical clamp done");
    // layer offset never moves here, so the field halves keep their reset order
    field_case(12'd1000, 1'b0, 1'b1, 1'b0);
    field_case(12'd400, 1'b0, 1'b1, 1'b1);
    field_case(12'd400, 1'b1, 1'b1, 1'b1);
    field_case(12'd1000, 1'b1, 1'b0, 1'b0);
    $display("test field detect done");
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
endmodule : cfd_top_test
